// file: common/pcp_pkg.sv
// Shared constants and carrier types of the parallel configuration port
package pcp_pkg;
	// Clock rates and times, printed figures in their own units
	localparam int CLK_SYS_PERIOD_NS  = 50;      // 20 MHz system clock
	localparam int STATUS_LOW_NS      = 45000;   // Least status low pulse
	localparam int CFG_MAX_PERIOD_NS  = 400;     // Slowest cfg_clock in use
	localparam int STARTUP_DELAY_MULT = 4;       // Periods before start-up
	// Derived cycle counts, least times rounded up
	localparam logic [15:0] STATUS_LOW_CYC = 16'((STATUS_LOW_NS
		+ CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS);
	localparam logic [15:0] STARTUP_DELAY_CYC = 16'((STARTUP_DELAY_MULT
		* CFG_MAX_PERIOD_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS);
	localparam logic [15:0] INIT_CLOCKS = 16'h0c78;  // 3192 clocks
	localparam logic [15:0] FALL_EDGES  = 16'h0002;  // Falls after complete
	// Data path shape
	localparam int BYTE_W     = 8;
	localparam int FIFO_DEPTH = 8;
	// Scheme select encodings
	localparam logic [1:0] SCHEME_FAST_PARALLEL    = 2'h0;
	localparam logic [1:0] SCHEME_PASSIVE_SERIAL   = 2'h1;
	localparam logic [1:0] SCHEME_ACTIVE_SERIAL    = 2'h2;

	// Loader sequence
	typedef enum logic [3:0] {
		S_RESET   = 4'h0,  // Pulling status low
		S_RELEASE = 4'h1,  // Waiting for shared status line high
		S_LOAD    = 4'h2,  // Taking configuration bytes
		S_WAIT    = 4'h3,  // Waiting for shared complete line
		S_FALL    = 4'h4,  // Counting cfg_clock falls
		S_DELAY   = 4'h5,  // Start-up clock enable delay
		S_INIT    = 4'h6,  // Initialisation count
		S_USER    = 4'h7,  // User mode
		S_ERROR   = 4'h8   // Halted after an error
	} pcp_state_type;

	// Every pin sampled from outside the clock domain
	typedef struct packed {
		logic       cfg_clock;          // Host configuration clock
		logic       user_startup_clock; // Optional start-up clock
		logic       config_request_n;   // Reconfiguration request
		logic       config_status_n;    // Wired status line level
		logic       config_complete;    // Wired completion line level
		logic [1:0] scheme_select_pins; // Scheme straps
		logic       use_startup_clock;  // Start-up clock option
		logic       data0_user_drive;   // Data bit 0 user drive option
		logic [7:0] data;               // Parallel data bus
	} pcp_pins_type;
endpackage

// file: src/pcp_loader.sv
// Configuration loader of the parallel port and its byte FIFO

// Byte FIFO between the pin side and the configuration memory writer
module pcp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	input  wire logic         clk_sys,   // System clock
	input  wire logic         rst,       // Asynchronous reset
	input  wire logic         in_valid,  // Byte offered
	input  wire logic [W-1:0] in_data,   // Byte offered
	output logic              in_ready,  // Room for a byte
	output logic              out_valid, // Byte available
	output logic [W-1:0]      out_data,  // Oldest byte
	input  wire logic         out_ready  // Drain accepts
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	// Whole FIFO state in one record
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem; // Storage
		logic [AW-1:0]           wr;  // Write pointer
		logic [AW-1:0]           rd;  // Read pointer
		logic [CW-1:0]           cnt; // Fill level
	} pcp_fifo_st_type;

	pcp_fifo_st_type st_q;  // Registered state
	pcp_fifo_st_type st_d;  // Next state

	logic push;  // Write this cycle
	logic pop;   // Read this cycle

	// Honest flags straight from the fill level
	assign in_ready  = (st_q.cnt != CW'(DEPTH));
	assign out_valid = (st_q.cnt != '0);
	assign out_data  = st_q.mem[st_q.rd];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and level update
	always_comb begin
		st_d = st_q;
		if (push) begin
			st_d.mem[st_q.wr] = in_data;
			st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
		end
		if (pop) begin
			st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
		end
		st_d.cnt = st_q.cnt + CW'(push) - CW'(pop);
	end

	// State register
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// Overview of operation
// - Released status line means ready for data
// - Bytes captured on cfg_clock rising edge
// - Fast parallel completes one byte early
// - Two cfg_clock falls start initialisation
// - Start-up clock ignored while loading
// - Optional start-up clock, delay, 3192 clocks
// - Release init_complete on entering user mode
// - User mode removes user pin pull-ups
// - Data bit zero tri-stated in user mode unless the drive option is set
// - No maximum cfg_clock period, pause allowed
// - Wait for shared completion line high
// - Shared status low halts every device
// - Request low in user mode reconfigures
// - Completion held low until loading finished
// - Start-up delay at least four clock periods
// - Error pulls the status line low
module pcp_loader (
	input  wire logic        clk_sys,              // System clock
	input  wire logic        rst,                  // Asynchronous reset
	input  wire logic        cfg_clock,            // Host clock pin
	input  wire logic [7:0]  cfg_data,             // Parallel data pins
	input  wire logic        user_startup_clock,   // Start-up clock pin
	input  wire logic        config_request_n,     // Request pin
	input  wire logic        config_status_n_in,   // Status line level
	output logic             config_status_n_out,  // Status drive value
	output logic             config_status_n_oe_n, // Low pulls line
	input  wire logic        config_complete_in,   // Completion line level
	output logic             config_complete_out,  // Completion drive
	output logic             config_complete_oe_n, // Low pulls line
	output logic             init_complete_out,    // Init drive value
	output logic             init_complete_oe_n,   // Low pulls line
	input  wire logic [1:0]  scheme_select_pins,   // Scheme straps
	input  wire logic        use_startup_clock,    // Start-up clock option
	input  wire logic        data0_user_drive,     // Bit zero drive option
	input  wire logic        user_data0,           // User value for bit 0
	output logic             data0_out,            // Bit zero drive value
	output logic             data0_oe_n,           // Low drives bit zero
	input  wire logic [31:0] image_bytes,          // Image length in bytes
	output logic             user_mode,            // Device in user mode
	output logic             user_pullup_en,       // Weak pull-ups on
	output logic             cfg_byte_valid,       // Byte to memory
	output logic [7:0]       cfg_byte,             // Byte to memory
	input  wire logic        cfg_byte_ready        // Memory accepts
);
	// Whole loader state in one record
	typedef struct packed {
		pcp_pkg::pcp_state_type state; // Sequence state
		pcp_pkg::pcp_pins_type  s1;    // Synchroniser first stage
		pcp_pkg::pcp_pins_type  s2;    // Synchroniser second stage
		pcp_pkg::pcp_pins_type  s3;    // Edge detect history
		logic [15:0]            timer; // Shared step counter
		logic [31:0]            bytes; // Bytes taken
		logic                   push;  // Byte offered to FIFO
		logic [7:0]             byte_q;// Captured byte
		logic                   done;  // Completion released
		logic                   init;  // Init line released
		logic                   d0;    // Registered user bit zero
	} pcp_st_type;

	pcp_st_type st_q;  // Registered state
	pcp_st_type st_d;  // Next state

	pcp_pkg::pcp_pins_type pins;  // Raw pin bundle
	logic rise_cfg;               // cfg_clock rising edge
	logic fall_cfg;               // cfg_clock falling edge
	logic rise_usr;               // Start-up clock rising edge
	logic fifo_ready;             // FIFO has room
	logic overrun;                // Byte arrived with FIFO full
	logic [31:0] done_at;         // Byte count that releases completion
	logic more;                   // Bytes still owed after completion

	assign pins = '{cfg_clock: cfg_clock,
		user_startup_clock: user_startup_clock,
		config_request_n: config_request_n,
		config_status_n: config_status_n_in,
		config_complete: config_complete_in,
		scheme_select_pins: scheme_select_pins,
		use_startup_clock: use_startup_clock,
		data0_user_drive: data0_user_drive, data: cfg_data};

	// Edges only from the second stage onward
	assign rise_cfg = st_q.s2.cfg_clock & ~st_q.s3.cfg_clock;
	assign fall_cfg = ~st_q.s2.cfg_clock & st_q.s3.cfg_clock;
	assign rise_usr = st_q.s2.user_startup_clock
		& ~st_q.s3.user_startup_clock;
	// The host cannot be stalled, so a full FIFO is a load error
	assign overrun  = st_q.push & ~fifo_ready;
	// one byte early in fast parallel
	assign done_at  = (st_q.s2.scheme_select_pins
		== pcp_pkg::SCHEME_FAST_PARALLEL) ? image_bytes - 32'h1
		: image_bytes;
	assign more     = st_q.bytes < image_bytes;

	// Sequence and capture logic
	always_comb begin
		st_d = st_q;
		st_d.s1 = pins;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.push = 1'b0;
		st_d.d0 = user_data0;
		case (st_q.state)
			// status held low for the least pulse
			pcp_pkg::S_RESET: begin
				st_d.timer = st_q.timer + 16'h1;
				if (st_q.timer == pcp_pkg::STATUS_LOW_CYC - 16'h1) begin
					st_d.state = pcp_pkg::S_RELEASE;
				end
			end
			// ready once the shared line is high
			pcp_pkg::S_RELEASE: begin
				if (st_q.s2.config_status_n) begin
					st_d.state = pcp_pkg::S_LOAD;
					st_d.bytes = '0;
				end
			end
			// capture on rising edge, no timeout
			pcp_pkg::S_LOAD: begin
				if (rise_cfg) begin
					st_d.push = 1'b1;
					st_d.byte_q = st_q.s2.data;
					st_d.bytes = st_q.bytes + 32'h1;
					if (st_q.bytes + 32'h1 == done_at) begin
						st_d.done = 1'b1;
						st_d.state = pcp_pkg::S_WAIT;
					end
				end
			end
			pcp_pkg::S_WAIT: begin
				if (st_q.s2.config_complete) begin
					st_d.state = pcp_pkg::S_FALL;
					st_d.timer = '0;
				end
			end
			pcp_pkg::S_FALL: begin
				if (fall_cfg) begin
					st_d.timer = st_q.timer + 16'h1;
					if (st_q.timer == pcp_pkg::FALL_EDGES - 16'h1) begin
						st_d.timer = '0;
						st_d.state = st_q.s2.use_startup_clock
							? pcp_pkg::S_DELAY : pcp_pkg::S_INIT;
					end
				end
			end
			// enable delay on the system clock
			pcp_pkg::S_DELAY: begin
				st_d.timer = st_q.timer + 16'h1;
				if (st_q.timer == pcp_pkg::STARTUP_DELAY_CYC - 16'h1) begin
					st_d.timer = '0;
					st_d.state = pcp_pkg::S_INIT;
				end
			end
			// count start-up clocks or system clocks
			pcp_pkg::S_INIT: begin
				if (rise_usr || !st_q.s2.use_startup_clock) begin
					st_d.timer = st_q.timer + 16'h1;
					if (st_q.timer == pcp_pkg::INIT_CLOCKS - 16'h1) begin
						// release init and enter user mode
						st_d.init = 1'b1;
						st_d.state = pcp_pkg::S_USER;
					end
				end
			end
			// User mode holds until a request
			pcp_pkg::S_USER: begin
				st_d.state = pcp_pkg::S_USER;
			end
			pcp_pkg::S_ERROR: begin
				st_d.state = pcp_pkg::S_ERROR;
			end
			default: begin
				st_d.state = pcp_pkg::S_RESET;
			end
		endcase
		// Last byte of a fast parallel image after completion
		if ((st_q.state == pcp_pkg::S_WAIT || st_q.state == pcp_pkg::S_FALL)
			&& rise_cfg && more) begin
			st_d.push = 1'b1;
			st_d.byte_q = st_q.s2.data;
			st_d.bytes = st_q.bytes + 32'h1;
		end
		// chain error or overrun halts loading
		if ((st_q.state == pcp_pkg::S_LOAD || st_q.state == pcp_pkg::S_WAIT
			|| st_q.state == pcp_pkg::S_FALL)
			&& (!st_q.s2.config_status_n || overrun)) begin
			st_d.state = pcp_pkg::S_ERROR;
			st_d.push = 1'b0;
			st_d.done = 1'b0;
		end
		if (!st_q.s2.config_request_n) begin
			st_d.state = pcp_pkg::S_RESET;
			st_d.timer = '0;
			st_d.push = 1'b0;
			st_d.done = 1'b0;
			st_d.init = 1'b0;
		end
	end

	// State register, power-up starts in reset with status low
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// Byte buffer towards the configuration memory
	pcp_fifo #(
		.W     (pcp_pkg::BYTE_W),
		.DEPTH (pcp_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst       (rst),
		.in_valid  (st_q.push),
		.in_data   (st_q.byte_q),
		.in_ready  (fifo_ready),
		.out_valid (cfg_byte_valid),
		.out_data  (cfg_byte),
		.out_ready (cfg_byte_ready)
	);

	// Open-drain lines only ever pull low
	assign config_status_n_out  = 1'b0;
	assign config_complete_out  = 1'b0;
	assign init_complete_out    = 1'b0;
	// pull status in reset and error
	assign config_status_n_oe_n = !(st_q.state == pcp_pkg::S_RESET
		|| st_q.state == pcp_pkg::S_ERROR);
	assign config_complete_oe_n = st_q.done;
	assign init_complete_oe_n   = st_q.init;
	assign user_mode            = (st_q.state == pcp_pkg::S_USER);
	assign user_pullup_en       = !user_mode;
	// bit zero floats unless the option drives it
	assign data0_oe_n = !(user_mode && st_q.s2.data0_user_drive);
	assign data0_out  = st_q.d0;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	sequence req_low_in_user;
		user_mode && !st_q.s2.config_request_n;
	endsequence
	sequence restart_pulls_status;
		st_q.state == pcp_pkg::S_RESET && !config_status_n_oe_n;
	endsequence

	a_load_after_release: assert property (
		st_q.state == pcp_pkg::S_RELEASE && st_q.s2.config_status_n
		&& st_q.s2.config_request_n |=> st_q.state == pcp_pkg::S_LOAD)
		else $error("release did not start loading");
	a_capture_rise: assert property (
		st_q.state == pcp_pkg::S_LOAD && rise_cfg && !overrun
		&& st_q.s2.config_status_n && st_q.s2.config_request_n
		|=> st_q.push && st_q.byte_q == $past(st_q.s2.data))
		else $error("byte not captured on rising edge");
	a_complete_early: assert property (
		$rose(st_q.done) |-> st_q.bytes == done_at)
		else $error("completion released at wrong count");
	a_two_falls: assert property (
		st_q.state == pcp_pkg::S_FALL && fall_cfg && st_q.timer == 16'h1
		&& st_q.s2.config_request_n && st_q.s2.config_status_n
		|=> st_q.state inside {pcp_pkg::S_DELAY, pcp_pkg::S_INIT})
		else $error("initialisation not started after two falls");
	a_usr_ignored: assert property (
		st_q.state == pcp_pkg::S_LOAD && !rise_cfg
		|=> $stable(st_q.bytes))
		else $error("byte count moved without cfg_clock");
	a_init_count: assert property (
		st_q.state == pcp_pkg::S_INIT && st_q.timer
		== pcp_pkg::INIT_CLOCKS - 16'h1 && st_q.s2.config_request_n
		&& (rise_usr || !st_q.s2.use_startup_clock)
		|=> user_mode ##1 user_mode || !st_q.s2.config_request_n)
		else $error("user mode not entered after init count");
	a_init_release: assert property (
		user_mode == init_complete_oe_n)
		else $error("init line disagrees with user mode");
	a_no_pullups: assert property (
		user_mode |-> !user_pullup_en)
		else $error("pull-ups left on in user mode");
	a_data0_float: assert property (
		user_mode && !st_q.s2.data0_user_drive |-> data0_oe_n)
		else $error("bit zero driven in user mode");
	a_pause_ok: assert property (
		st_q.state == pcp_pkg::S_LOAD && !rise_cfg && !overrun
		&& st_q.s2.config_status_n && st_q.s2.config_request_n
		|=> st_q.state == pcp_pkg::S_LOAD)
		else $error("loading left while clock paused");
	a_wait_shared: assert property (
		st_q.state == pcp_pkg::S_WAIT && !st_q.s2.config_complete
		|=> st_q.state != pcp_pkg::S_FALL)
		else $error("left wait before shared completion");
	a_chain_halt: assert property (
		st_q.state == pcp_pkg::S_LOAD && !st_q.s2.config_status_n
		&& st_q.s2.config_request_n |=> st_q.state == pcp_pkg::S_ERROR)
		else $error("chain error did not halt loading");
	a_reconfig: assert property (
		req_low_in_user |=> restart_pulls_status)
		else $error("request did not restart configuration");
	a_complete_low: assert property (
		st_q.state inside {pcp_pkg::S_RESET, pcp_pkg::S_RELEASE,
		pcp_pkg::S_LOAD} |-> !config_complete_oe_n)
		else $error("completion released during loading");
	a_delay_len: assert property (
		$rose(st_q.state == pcp_pkg::S_DELAY) && st_q.s2.config_request_n
		|-> ##31 st_q.state == pcp_pkg::S_DELAY
		|| !st_q.s2.config_request_n)
		else $error("start-up delay too short");
	a_error_pull: assert property (
		st_q.state == pcp_pkg::S_ERROR |-> !config_status_n_oe_n)
		else $error("error without status pulled low");
	a_error_hold: assert property (
		st_q.state == pcp_pkg::S_ERROR && st_q.s2.config_request_n
		|=> st_q.state == pcp_pkg::S_ERROR && !st_q.push)
		else $error("error state left without request");
endmodule

// file: test/pcp_host_model.sv
// Behavioural configuration host driving the loader's link pins
module pcp_host_model (
	input  wire logic clk_sys,          // Bench clock, aligns stimulus
	output logic      cfg_clock,        // Host configuration clock
	output logic [7:0] cfg_data,        // Parallel data bus
	output logic      config_request_n, // Reconfiguration request
	output logic      status_pull_n     // Low pulls the status line
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int HALF_NS = 200; // Half of the 400 ns link period

	// Clock parked low and data driven, never floating
	initial begin
		cfg_clock        = 1'b0;
		cfg_data         = 8'h00;
		config_request_n = 1'b1;
		status_pull_n    = 1'b1;
	end

	// one clock pulse, parked low after
	task automatic pulse();
		@(posedge clk_sys);
		#2;
		cfg_clock = 1'b1;
		#HALF_NS cfg_clock = 1'b0;
		// Low phase held long enough for the loader's edge detector
		repeat (3) @(posedge clk_sys);
		#2;
	endtask

	// one byte, set while the clock is low
	task automatic send_byte(input logic [7:0] b);
		@(posedge clk_sys);
		#2;
		cfg_data = b;
		// Setup counted in edges, never on an edge itself
		repeat (3) @(posedge clk_sys);
		pulse();
	endtask

	// request level, restart after a failed load
	task automatic set_request(input logic v);
		@(posedge clk_sys);
		#2;
		config_request_n = v;
	endtask

	// Pull the shared status line low for some cycles
	task automatic pull_status(input int cyc);
		@(posedge clk_sys);
		#2;
		status_pull_n = 1'b0;
		repeat (cyc) @(posedge clk_sys);
		#2;
		status_pull_n = 1'b1;
	endtask
endmodule

// file: test/tb.sv
// Self-checking bench of the parallel configuration loader
module tb;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clk_sys;      // 20 MHz system clock
	logic        rst;          // Asynchronous reset
	logic        cfg_clock;    // Link clock from host
	logic [7:0]  cfg_data;     // Link data from host
	logic        request_n;    // Request from host
	logic        host_pull_n;  // Host pull on status
	logic        peer_pull_n;  // Chain peer pull on completion
	logic        su_clock;     // Start-up clock pin
	logic        su_run;       // Start-up clock gate
	logic        status_oe_n;  // Device pull on status
	logic        done_oe_n;    // Device pull on completion
	logic        init_oe_n;    // Device pull on init line
	logic        status_line;  // Resolved status line
	logic        done_line;    // Resolved completion line
	logic [1:0]  scheme;       // Scheme straps
	logic        use_su;       // Start-up clock option
	logic        d0_drive;     // Bit zero drive option
	logic        user_data0;   // User value for bit zero
	logic        data0_out;    // Bit zero drive value
	logic        data0_oe_n;   // Bit zero enable
	logic        status_out;   // Status drive value
	logic        done_out;     // Completion drive value
	logic        init_out;     // Init drive value
	logic        user_mode;    // User mode flag
	logic        pullup_en;    // Weak pull-ups on
	logic        byte_valid;   // FIFO byte available
	logic        byte_ready;   // Drain accepts
	logic [7:0]  byte_out;     // Oldest FIFO byte
	logic [31:0] image_bytes;  // Image length
	logic [7:0]  popped[$];    // Bytes drained from FIFO
	int          error_cnt;    // Mismatches
	int          cmp_count;    // Comparisons made

	// Pull-ups on the wired lines, any party may pull low
	assign status_line = status_oe_n & host_pull_n;
	assign done_line   = done_oe_n & peer_pull_n;

	always #25 clk_sys = ~clk_sys;
	// Free start-up clock, 400 ns period when gated on
	always #200 su_clock = su_run ? ~su_clock : 1'b0;
	// Collect every byte the drain accepts
	always @(posedge clk_sys) begin
		if (byte_valid === 1'b1 && byte_ready === 1'b1) begin
			popped.push_back(byte_out);
		end
	end

	pcp_host_model host (
		.clk_sys          (clk_sys),
		.cfg_clock        (cfg_clock),
		.cfg_data         (cfg_data),
		.config_request_n (request_n),
		.status_pull_n    (host_pull_n)
	);

	pcp_loader DUT (
		.clk_sys              (clk_sys),
		.rst                  (rst),
		.cfg_clock            (cfg_clock),
		.cfg_data             (cfg_data),
		.user_startup_clock   (su_clock),
		.config_request_n     (request_n),
		.config_status_n_in   (status_line),
		.config_status_n_out  (status_out),
		.config_status_n_oe_n (status_oe_n),
		.config_complete_in   (done_line),
		.config_complete_out  (done_out),
		.config_complete_oe_n (done_oe_n),
		.init_complete_out    (init_out),
		.init_complete_oe_n   (init_oe_n),
		.scheme_select_pins   (scheme),
		.use_startup_clock    (use_su),
		.data0_user_drive     (d0_drive),
		.user_data0           (user_data0),
		.data0_out            (data0_out),
		.data0_oe_n           (data0_oe_n),
		.image_bytes          (image_bytes),
		.user_mode            (user_mode),
		.user_pullup_en       (pullup_en),
		.cfg_byte_valid       (byte_valid),
		.cfg_byte             (byte_out),
		.cfg_byte_ready       (byte_ready)
	);

	task automatic stop_test();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic chk_num(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic sig(input int sel);
		case (sel)
			0: return status_line;
			1: return done_line;
			default: return user_mode;
		endcase
	endfunction

	// Bounded wait for a level, then judged; n counts cycles
	task automatic wait_lvl(input int sel, input logic v, input int lim,
		output int n);
		n = 0;
		while (sig(sel) !== v && n < lim) begin
			@(posedge clk_sys);
			#2;
			n++;
		end
		chk_bit(sig(sel), v);
	endtask

	// Whole cycles, ending just after an edge so outputs are settled
	task automatic wait_cyc(input int c);
		repeat (c) @(posedge clk_sys);
		#2;
	endtask

	// Restart with new straps, then wait for released status
	task automatic boot(input logic [1:0] s, input logic su, input int img);
		int n;
		host.set_request(1'b0);
		scheme = s;
		use_su = su;
		image_bytes = 32'(img);
		popped.delete();
		wait_cyc(20);
		chk_bit(user_mode, 1'b0);
		chk_bit(done_line, 1'b0);
		chk_bit(pullup_en, 1'b1);
		host.set_request(1'b1);
		wait_lvl(0, 1'b1, 1200, n);
		wait_cyc(6);
	endtask

	// Fast parallel load with a paused link and a slow chain peer
	task automatic t_fast();
		logic [7:0] img[4];
		int n;
		img = '{8'ha5, 8'h3c, 8'h0f, 8'hf0};
		boot(pcp_pkg::SCHEME_FAST_PARALLEL, 1'b0, 4);
		peer_pull_n = 1'b0;
		host.send_byte(img[0]);
		wait_cyc(400);
		chk_bit(status_line, 1'b1);
		host.send_byte(img[1]);
		wait_cyc(8);
		chk_bit(done_oe_n, 1'b0);
		host.send_byte(img[2]);
		wait_cyc(8);
		chk_bit(done_oe_n, 1'b1);
		host.send_byte(img[3]);
		host.pulse();
		host.pulse();
		wait_cyc(3400);
		chk_bit(user_mode, 1'b0);
		peer_pull_n = 1'b1;
		host.pulse();
		host.pulse();
		wait_lvl(2, 1'b1, 3400, n);
		chk_bit(n >= 3192 && n <= 3210, 1'b1);
		chk_bit(init_oe_n, 1'b1);
		chk_bit(pullup_en, 1'b0);
		chk_bit(data0_oe_n, 1'b1);
		chk_num(32'({status_out, done_out, init_out}), 32'h0);
		chk_num(32'(popped.size()), 32'h4);
		for (int i = 0; i < 4; i++) begin
			chk_num(32'(popped[i]), 32'(img[i]));
		end
	endtask

	// Serial load, start-up clock running throughout
	task automatic t_serial_su();
		int n;
		time t0;
		d0_drive = 1'b1;
		boot(pcp_pkg::SCHEME_PASSIVE_SERIAL, 1'b1, 2);
		su_run = 1'b1;
		host.send_byte(8'h81);
		wait_cyc(8);
		chk_bit(done_oe_n, 1'b0);
		host.send_byte(8'h7e);
		wait_lvl(1, 1'b1, 10, n);
		// Delay is reckoned from the second fall; measure from completion, before the falls
		t0 = $time;
		host.pulse();
		host.pulse();
		wait_lvl(2, 1'b1, 26000, n);
		n = int'(($time - t0) / pcp_pkg::CLK_SYS_PERIOD_NS);
		chk_bit(n >= 32 + 3191 * 8 && n <= 64 + 3192 * 8, 1'b1);
		chk_num(32'(popped.size()), 32'h2);
		chk_num(32'(popped[1]), 32'h7e);
		chk_bit(data0_oe_n, 1'b0);
		chk_bit(data0_out, user_data0);
		user_data0 = 1'b0;
		wait_cyc(2);
		chk_bit(data0_out, 1'b0);
		user_data0 = 1'b1;
		su_run = 1'b0;
		d0_drive = 1'b0;
	endtask

	// Stalled drain: ninth byte overruns the FIFO
	task automatic t_overrun();
		int n;
		int got;
		byte_ready = 1'b0;
		boot(pcp_pkg::SCHEME_FAST_PARALLEL, 1'b0, 32);
		for (int i = 0; i < 8; i++) begin
			host.send_byte(8'(8'h10 + i));
		end
		chk_bit(status_line, 1'b1);
		host.send_byte(8'h55);
		wait_lvl(0, 1'b0, 10, n);
		byte_ready = 1'b1;
		wait_cyc(20);
		got = popped.size();
		chk_num(32'(got), 32'h8);
		host.send_byte(8'h66);
		wait_cyc(20);
		chk_num(32'(popped.size()), 32'(got));
		chk_bit(status_line, 1'b0);
	endtask

	// Another chain device flags an error mid-load
	task automatic t_chain_error();
		boot(pcp_pkg::SCHEME_ACTIVE_SERIAL, 1'b0, 32);
		host.send_byte(8'h01);
		host.pull_status(4);
		wait_cyc(6);
		chk_bit(status_oe_n, 1'b0);
		host.send_byte(8'h02);
		wait_cyc(10);
		chk_num(32'(popped.size()), 32'h1);
		chk_bit(done_oe_n, 1'b0);
		boot(pcp_pkg::SCHEME_FAST_PARALLEL, 1'b0, 4);
	endtask

	// Watchdog, well beyond the expected run length
	initial begin
		#4000000;
		error_cnt++;
		stop_test();
	end

	// Main sequence
	initial begin
		clk_sys = 1'b0;
		rst = 1'b1;
		su_clock = 1'b0;
		su_run = 1'b0;
		peer_pull_n = 1'b1;
		scheme = 2'h0;
		use_su = 1'b0;
		d0_drive = 1'b0;
		user_data0 = 1'b1;
		byte_ready = 1'b1;
		image_bytes = 32'h4;
		error_cnt = 0;
		cmp_count = 0;
		repeat (16) @(posedge clk_sys);
		#2;
		rst = 1'b0;
		t_fast();
		t_serial_su();
		t_overrun();
		t_chain_error();
		stop_test();
	end
endmodule
